// File: dct_timers.sv
`timescale 1ns/10ps
`default_nettype none
module dct_timers (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Mode and source configuration
  input  wire logic [1:0] first_mode_select,
  input  wire logic [1:0] second_mode_select,
  input  wire logic       first_count_source_select,
  input  wire logic       second_count_source_select,
  input  wire logic       first_clock_select,
  input  wire logic       second_clock_select,
  input  wire logic [1:0] prescale_select,
  // Run and gate control
  input  wire logic       first_run_bit,
  input  wire logic       second_run_bit,
  input  wire logic       first_gate_bit,
  input  wire logic       second_gate_bit,
  input  wire logic       first_gate_polarity,
  input  wire logic       second_gate_polarity,
  // Interrupt enables and flag clears
  input  wire logic       first_overflow_irq_enable,
  input  wire logic       second_overflow_irq_enable,
  input  wire logic       first_overflow_flag_clr,
  input  wire logic       second_overflow_flag_clr,
  // Pins
  input  wire logic       first_count_pin,
  input  wire logic       second_count_pin,
  input  wire logic       first_gate_input,
  input  wire logic       second_gate_input,
  input  wire logic       ext_clk,
  // Software byte writes
  input  wire logic [7:0] sw_wdata,
  input  wire logic       first_count_low_byte_we,
  input  wire logic       first_count_high_byte_we,
  input  wire logic       second_count_low_byte_we,
  input  wire logic       second_count_high_byte_we,
  // Count bytes read back
  output logic      [7:0] first_count_low_byte,
  output logic      [7:0] first_count_high_byte,
  output logic      [7:0] second_count_low_byte,
  output logic      [7:0] second_count_high_byte,
  // Flags, interrupts, overflow for other blocks
  output logic            first_overflow_flag,
  output logic            second_overflow_flag,
  output logic            first_overflow_irq,
  output logic            second_overflow_irq,
  output logic            second_overflow_pulse
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic       tf0;
    logic       tf1;
    logic       irq0;
    logic       irq1;
    logic       ovf1;
    logic [5:0] presc_cnt;
    logic [2:0] ext_div;
  } dct_state_t;

  dct_state_t q;
  dct_state_t d;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // One count step; returns {overflow, high, low}
  function automatic logic [16:0] dct_step(
    input logic [1:0] m,
    input logic [7:0] h,
    input logic [7:0] l
  );
    logic [12:0] v13;
    logic [15:0] v16;
    logic [16:0] r;
    v13 = {h, l[4:0]} + 13'h0001;
    v16 = {h, l} + 16'h0001;
    r   = {1'b0, h, l};
    case (m)
      // Top three low bits left as they are
      dct_pkg::MODE_13BIT:
        r = {(v13 == 13'h0000), v13[12:5], l[7:5], v13[4:0]};
      dct_pkg::MODE_16BIT:
        r = {(v16 == 16'h0000), v16};
      // High byte returned untouched, acts as reload
      dct_pkg::MODE_RELOAD:
        if (l == dct_pkg::BYTE_ALL_ONES)
          r = {1'b1, h, h};
        else
          r = {1'b0, h, l + 8'h01};
      default:
        r = {(l == dct_pkg::BYTE_ALL_ONES), h, l + 8'h01};
    endcase
    return r;
  endfunction : dct_step

  // Prescaler reload for the internal divisors
  function automatic logic [5:0] dct_presc_load(input logic [1:0] c);
    logic [5:0] r;
    case (c)
      dct_pkg::PRESC_DIV12: r = dct_pkg::DIV12_LOAD;
      dct_pkg::PRESC_DIV4:  r = dct_pkg::DIV4_LOAD;
      dct_pkg::PRESC_DIV48: r = dct_pkg::DIV48_LOAD;
      default:              r = dct_pkg::DIV12_LOAD;
    endcase
    return r;
  endfunction : dct_presc_load

  // ------------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------------
  logic [4:0] sync_level;
  logic [4:0] sync_fall;

  dct_sync_edge #(
    .W (5)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .raw_in   ({ext_clk, second_gate_input, first_gate_input,
                second_count_pin, first_count_pin}),
    .level    (sync_level),
    .fall     (sync_fall)
  );

  // ------------------------------------------------------------------
  // Count enables
  // ------------------------------------------------------------------
  logic        presc_tick;
  logic        gate_act0;
  logic        gate_act1;
  logic        t0_split;
  logic        src0;
  logic        src1;
  logic        run1;
  logic        inc0;
  logic        inc1;
  logic        th0_inc;
  logic        th0_wrap;
  logic [16:0] st0;
  logic [16:0] st1;

  // External clock path counts eight synchronised falls
  assign presc_tick = (prescale_select == dct_pkg::PRESC_EXT8) ?
                      (sync_fall[4] && q.ext_div == dct_pkg::EXT8_LAST) :
                      (q.presc_cnt == 6'h00);
  assign gate_act0  = sync_level[2] == first_gate_polarity;
  assign gate_act1  = sync_level[3] == second_gate_polarity;
  assign t0_split   = first_mode_select == dct_pkg::MODE_SPLIT;
  // Pin edge, system clock or prescaler
  assign src0 = first_count_source_select ? sync_fall[0] :
                (first_clock_select | presc_tick);
  // No pin clocking while the first timer is split
  assign src1 = (second_count_source_select && !t0_split) ?
                sync_fall[1] :
                (second_clock_select | presc_tick);
  // Split mode hands second run control to its mode field
  assign run1 = t0_split ? 1'b1 :
                (second_run_bit && (!second_gate_bit || gate_act1));
  assign inc0 = first_run_bit && (!first_gate_bit || gate_act0) &&
                src0;
  assign inc1 = (second_mode_select != dct_pkg::MODE_SPLIT) &&
                run1 && src1;
  // Split high byte: internal clock, second run bit
  assign th0_inc  = t0_split && second_run_bit &&
                    (second_clock_select | presc_tick);
  assign th0_wrap = th0_inc && q.th0 == dct_pkg::BYTE_ALL_ONES;
  assign st0 = dct_step(first_mode_select, q.th0, q.tl0);
  assign st1 = dct_step(second_mode_select, q.th1, q.tl1);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // Count, then software writes, then flags; set beats clear
  always_comb
  begin
    d = q;
    if (prescale_select != dct_pkg::PRESC_EXT8)
    begin
      if (q.presc_cnt == 6'h00)
        d.presc_cnt = dct_presc_load(prescale_select);
      else
        d.presc_cnt = q.presc_cnt - 6'h01;
    end
    if (sync_fall[4])
      d.ext_div = q.ext_div + 3'h1;
    if (inc0)
    begin
      d.tl0 = st0[7:0];
      if (!t0_split)
        d.th0 = st0[15:8];
    end
    if (th0_inc)
      d.th0 = q.th0 + 8'h01;
    if (inc1)
    begin
      d.tl1 = st1[7:0];
      d.th1 = st1[15:8];
    end
    // Writes win over counting; run bit never touches count
    if (first_count_low_byte_we)
      d.tl0 = sw_wdata;
    if (first_count_high_byte_we)
      d.th0 = sw_wdata;
    if (second_count_low_byte_we)
      d.tl1 = sw_wdata;
    if (second_count_high_byte_we)
      d.th1 = sw_wdata;
    d.tf0  = (q.tf0 & ~first_overflow_flag_clr) |
             (inc0 & st0[16]);
    d.tf1  = (q.tf1 & ~second_overflow_flag_clr) |
             (t0_split ? th0_wrap : (inc1 & st1[16]));
    d.ovf1 = inc1 & st1[16];
    d.irq0 = q.tf0 & first_overflow_irq_enable;
    d.irq1 = q.tf1 & second_overflow_irq_enable;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign first_count_low_byte   = q.tl0;
  assign first_count_high_byte  = q.th0;
  assign second_count_low_byte  = q.tl1;
  assign second_count_high_byte = q.th1;
  assign first_overflow_flag    = q.tf0;
  assign second_overflow_flag   = q.tf1;
  assign first_overflow_irq     = q.irq0;
  assign second_overflow_irq    = q.irq1;
  assign second_overflow_pulse  = q.ovf1;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic no_wr0;
  logic no_wr1;
  assign no_wr0 = !first_count_low_byte_we && !first_count_high_byte_we;
  assign no_wr1 = !second_count_low_byte_we && !second_count_high_byte_we;
  property p_write_lands;
    first_count_low_byte_we |=> first_count_low_byte == $past(sw_wdata);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("low byte write did not land");
  property p_halt;
    (!first_run_bit && !t0_split && no_wr0) |=>
      $stable(first_count_low_byte) && $stable(first_count_high_byte);
  endproperty
  a_halt: assert property (p_halt)
    else $error("stopped timer changed");
  property p_wrap16;
    (inc0 && first_mode_select == dct_pkg::MODE_16BIT &&
     q.tl0 == 8'hff && q.th0 == 8'hff && no_wr0) |=>
      first_overflow_flag && first_count_low_byte == 8'h00 &&
      first_count_high_byte == 8'h00;
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap wrong");
  property p_reload;
    (inc0 && first_mode_select == dct_pkg::MODE_RELOAD &&
     q.tl0 == 8'hff && no_wr0) |=>
      first_count_low_byte == $past(q.th0) && $stable(first_count_high_byte);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload wrong");
  property p_carry13;
    (inc0 && first_mode_select == dct_pkg::MODE_13BIT &&
     q.tl0[4:0] == 5'h1f && q.th0 != 8'hff && no_wr0) |=>
      first_count_high_byte == $past(q.th0) + 8'h01 &&
      first_count_low_byte[4:0] == 5'h00 && !$rose(first_overflow_flag);
  endproperty
  a_carry13: assert property (p_carry13)
    else $error("13-bit carry wrong");
  property p_sticky;
    (first_overflow_flag && !first_overflow_flag_clr) |=>
      first_overflow_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");
  property p_irq_gate;
    (!second_overflow_irq_enable ##1 1'b1) |-> !second_overflow_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("masked interrupt forwarded");
  property p_irq_fwd;
    (first_overflow_flag && first_overflow_irq_enable) |=>
      first_overflow_irq;
  endproperty
  a_irq_fwd: assert property (p_irq_fwd)
    else $error("enabled interrupt missing");
  property p_t1_idle;
    (second_mode_select == dct_pkg::MODE_SPLIT && !t0_split && no_wr1) |=>
      $stable(second_count_low_byte) && $stable(second_count_high_byte);
  endproperty
  a_t1_idle: assert property (p_t1_idle)
    else $error("second timer ran in mode 3");
  property p_split_noflag;
    (t0_split && !second_overflow_flag && !th0_wrap) |=>
      !second_overflow_flag;
  endproperty
  a_split_noflag: assert property (p_split_noflag)
    else $error("second flag set by second timer");
  sequence s_div4;
    (presc_tick && prescale_select == dct_pkg::PRESC_DIV4)
      ##1 (!presc_tick && prescale_select == dct_pkg::PRESC_DIV4)[*3];
  endsequence
  property p_div4;
    s_div4 |=> presc_tick || prescale_select != dct_pkg::PRESC_DIV4;
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide by 4 period wrong");
  property p_pin_count;
    (first_count_source_select && first_run_bit && !first_gate_bit &&
     sync_fall[0] && first_mode_select == dct_pkg::MODE_16BIT &&
     no_wr0) |=> {first_count_high_byte, first_count_low_byte} ==
                 {$past(q.th0), $past(q.tl0)} + 16'h0001;
  endproperty
  a_pin_count: assert property (p_pin_count)
    else $error("pin edge not counted");
endmodule : dct_timers
`default_nettype wire

// File: dct_pkg.sv
package dct_pkg;

  // ------------------------------------------------------------------
  // Mode codes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // ------------------------------------------------------------------
  // Prescaler codes and divisors
  // ------------------------------------------------------------------
  localparam logic [1:0] PRESC_DIV12 = 2'h0;
  localparam logic [1:0] PRESC_DIV4 = 2'h1;
  localparam logic [1:0] PRESC_DIV48 = 2'h2;
  localparam logic [1:0] PRESC_EXT8 = 2'h3;
  localparam logic [5:0] DIV12_LOAD = 6'h0b;
  localparam logic [5:0] DIV4_LOAD = 6'h03;
  localparam logic [5:0] DIV48_LOAD = 6'h2f;
  localparam logic [2:0] EXT8_LAST = 3'h7;

  // ------------------------------------------------------------------
  // Count limits and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [4:0] LOW5_ALL_ONES = 5'h1f;
  localparam logic [7:0] COUNT_RST = 8'h00;

endpackage : dct_pkg

// File: dct_sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
module dct_sync_edge #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Raw asynchronous inputs
  input  wire logic [W-1:0] raw_in,
  // Synchronised level and falling-edge pulse
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dct_sync_t;

  dct_sync_t q;
  dct_sync_t d;

  // Shift chain; first stage feeds only the second
  always_comb
  begin
    d    = q;
    d.s1 = raw_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  // Edge from two settled samples only
  assign level = q.s2;
  assign fall  = q.s3 & ~q.s2;

endmodule : dct_sync_edge
`default_nettype wire

// File: dct_timers_test.sv
`timescale 1ns/10ps
`default_nettype none
module dct_timers_test;

  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic       core_clk, reset, ext_clk;
  logic [1:0] first_mode_select, second_mode_select, prescale_select;
  logic       first_count_source_select, second_count_source_select;
  logic       first_clock_select, second_clock_select;
  logic       first_run_bit, second_run_bit;
  logic       first_gate_bit, first_gate_polarity, first_gate_input;
  logic       first_overflow_irq_enable, second_overflow_irq_enable;
  logic       second_gate_bit, second_gate_polarity, second_count_pin;
  logic       first_overflow_flag_clr, second_overflow_flag_clr;
  logic       first_count_pin;
  logic [7:0] sw_wdata;
  logic [3:0] we_v;
  logic [7:0] fl, fh, sl, sh;
  logic       first_overflow_flag, second_overflow_flag;
  logic       first_overflow_irq, second_overflow_irq;
  logic       second_overflow_pulse;
  int         err_count, checks_done;

  // ------------------------------------------------------------------
  // Device under test
  // ------------------------------------------------------------------
  dct_timers DUT (
    .core_clk(core_clk), .reset(reset),
    .first_mode_select(first_mode_select),
    .second_mode_select(second_mode_select),
    .first_count_source_select(first_count_source_select),
    .second_count_source_select(second_count_source_select),
    .first_clock_select(first_clock_select),
    .second_clock_select(second_clock_select),
    .prescale_select(prescale_select),
    .first_run_bit(first_run_bit), .second_run_bit(second_run_bit),
    .first_gate_bit(first_gate_bit), .second_gate_bit(second_gate_bit),
    .first_gate_polarity(first_gate_polarity),
    .second_gate_polarity(second_gate_polarity),
    .first_overflow_irq_enable(first_overflow_irq_enable),
    .second_overflow_irq_enable(second_overflow_irq_enable),
    .first_overflow_flag_clr(first_overflow_flag_clr),
    .second_overflow_flag_clr(second_overflow_flag_clr),
    .first_count_pin(first_count_pin),
    .second_count_pin(second_count_pin),
    .first_gate_input(first_gate_input), .second_gate_input(1'b0),
    .ext_clk(ext_clk), .sw_wdata(sw_wdata),
    .first_count_low_byte_we(we_v[0]), .first_count_high_byte_we(we_v[1]),
    .second_count_low_byte_we(we_v[2]),
    .second_count_high_byte_we(we_v[3]),
    .first_count_low_byte(fl), .first_count_high_byte(fh),
    .second_count_low_byte(sl), .second_count_high_byte(sh),
    .first_overflow_flag(first_overflow_flag),
    .second_overflow_flag(second_overflow_flag),
    .first_overflow_irq(first_overflow_irq),
    .second_overflow_irq(second_overflow_irq),
    .second_overflow_pulse(second_overflow_pulse)
  );

  // ------------------------------------------------------------------
  // Clocks: 50 ns core, external source falls every 4 core cycles
  // ------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial
  begin
    ext_clk = 1'b0;
    forever
    begin
      repeat (2) @(posedge core_clk);
      ext_clk <= ~ext_clk;
    end
  end

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // One byte write; lands at the edge that samples the strobe
  task automatic wr(input int idx, input logic [7:0] val);
    @(posedge core_clk);
    sw_wdata <= val;
    we_v[idx] <= 1'b1;
    @(posedge core_clk);
    we_v <= 4'h0;
    #1;
  endtask : wr

  // Run bit high for exactly k sampling edges, so k steps at sysclk
  task automatic run_pulse(input logic which, input int k);
    @(posedge core_clk);
    if (which) second_run_bit <= 1'b1;
    else first_run_bit <= 1'b1;
    repeat (k) @(posedge core_clk);
    first_run_bit <= 1'b0;
    second_run_bit <= 1'b0;
    #1;
  endtask : run_pulse

  task automatic clr_flags();
    @(posedge core_clk);
    first_overflow_flag_clr <= 1'b1;
    second_overflow_flag_clr <= 1'b1;
    @(posedge core_clk);
    first_overflow_flag_clr <= 1'b0;
    second_overflow_flag_clr <= 1'b0;
    #1;
  endtask : clr_flags

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_mode1();
    @(posedge core_clk);
    first_mode_select <= dct_pkg::MODE_16BIT;
    first_clock_select <= 1'b1;
    first_overflow_irq_enable <= 1'b1;
    wr(0, 8'hff); wr(1, 8'hff);
    chk({fh, fl}, 16'hffff, "load");
    run_pulse(1'b0, 1);
    chk({fh, fl}, 16'h0000, "wrap16");
    chk({15'h0, first_overflow_flag}, 16'h0001, "flag");
    @(posedge core_clk); #1;
    chk({15'h0, first_overflow_irq}, 16'h0001, "irq on");
    wr(0, 8'h34); wr(1, 8'h12);
    run_pulse(1'b0, 3);
    chk({fh, fl}, 16'h1237, "no clear on run");
    clr_flags();
    chk({15'h0, first_overflow_flag}, 16'h0000, "flag clr");
    @(posedge core_clk);
    first_overflow_irq_enable <= 1'b0;
    wr(0, 8'hff); wr(1, 8'hff);
    run_pulse(1'b0, 1);
    repeat (2) @(posedge core_clk); #1;
    chk({14'h0, first_overflow_flag, first_overflow_irq}, 16'h0002,
        "masked");
    clr_flags();
    $display("test mode1 done");
  endtask : t_mode1

  task automatic t_mode0_mode2();
    @(posedge core_clk);
    first_mode_select <= dct_pkg::MODE_13BIT;
    wr(0, 8'h1f); wr(1, 8'h12);
    run_pulse(1'b0, 1);
    chk({fh, 3'h0, fl[4:0]}, 16'h1300, "carry5");
    chk({15'h0, first_overflow_flag}, 16'h0000, "no flag");
    wr(0, 8'hff); wr(1, 8'hff);
    run_pulse(1'b0, 1);
    chk({fh, 3'h0, fl[4:0]}, 16'h0000, "wrap13");
    chk({15'h0, first_overflow_flag}, 16'h0001, "flag13");
    clr_flags();
    @(posedge core_clk);
    first_mode_select <= dct_pkg::MODE_RELOAD;
    wr(1, 8'ha5); wr(0, 8'hfe);
    run_pulse(1'b0, 2);
    chk({fh, fl}, 16'ha5a5, "reload");
    chk({15'h0, first_overflow_flag}, 16'h0001, "flag8");
    run_pulse(1'b0, 1);
    chk({fh, fl}, 16'ha5a6, "after reload");
    clr_flags();
    $display("test mode0 mode2 done");
  endtask : t_mode0_mode2

  task automatic t_gate_pin();
    @(posedge core_clk);
    first_mode_select <= dct_pkg::MODE_16BIT;
    first_gate_bit <= 1'b1;
    first_gate_polarity <= 1'b1;
    wr(0, 8'h00); wr(1, 8'h00);
    repeat (4) @(posedge core_clk);
    run_pulse(1'b0, 6);
    chk({fh, fl}, 16'h0000, "gate shut");
    @(posedge core_clk);
    first_gate_polarity <= 1'b0;
    repeat (5) @(posedge core_clk);
    run_pulse(1'b0, 5);
    chk({fh, fl}, 16'h0005, "gate low active");
    @(posedge core_clk);
    first_gate_input <= 1'b1;
    repeat (5) @(posedge core_clk);
    run_pulse(1'b0, 4);
    chk({fh, fl}, 16'h0005, "gate inactive");
    @(posedge core_clk);
    first_gate_bit <= 1'b0;
    run_pulse(1'b0, 2);
    chk({fh, fl}, 16'h0007, "gate off");
    wr(0, 8'h00);
    @(posedge core_clk);
    first_count_source_select <= 1'b1;
    first_run_bit <= 1'b1;
    repeat (5)
    begin
      // Each level held three clocks, above the one-clock floor
      first_count_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      first_count_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    first_run_bit <= 1'b0;
    #1;
    chk({fh, fl}, 16'h0005, "pin falls");
    $display("test gate pin done");
  endtask : t_gate_pin

  task automatic t_presc();
    int wins [4] = '{96, 40, 96, 128};
    int exps [4] = '{8, 10, 2, 4};
    logic [15:0] c0;
    @(posedge core_clk);
    first_count_source_select <= 1'b0;
    first_clock_select <= 1'b0;
    first_run_bit <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      prescale_select <= i[1:0];
      repeat (200) @(posedge core_clk);
      #1 c0 = {fh, fl};
      repeat (wins[i]) @(posedge core_clk);
      #1;
      chk({fh, fl} - c0, exps[i][15:0], "prescale");
    end
    @(posedge core_clk);
    first_run_bit <= 1'b0;
    $display("test prescaler done");
  endtask : t_presc

  task automatic t_split();
    logic [15:0] c0;
    @(posedge core_clk);
    first_mode_select <= dct_pkg::MODE_SPLIT;
    second_mode_select <= dct_pkg::MODE_16BIT;
    first_clock_select <= 1'b1;
    second_clock_select <= 1'b1;
    second_count_source_select <= 1'b1;
    second_overflow_irq_enable <= 1'b1;
    wr(0, 8'hfe); wr(1, 8'hff);
    run_pulse(1'b0, 2);
    chk({fh, fl}, 16'hff00, "split low");
    chk({15'h0, first_overflow_flag}, 16'h0001, "split flag");
    c0 = {sh, sl};
    repeat (10) @(posedge core_clk); #1;
    chk({sh, sl} - c0, 16'h000a, "second free run");
    wr(3, 8'hff); wr(2, 8'hff);
    @(posedge core_clk); #1;
    chk({15'h0, second_overflow_pulse}, 16'h0001, "split pulse");
    repeat (4) @(posedge core_clk); #1;
    chk({13'h0, second_overflow_flag, second_overflow_irq,
         second_overflow_pulse}, 16'h0000, "no second flag");
    @(posedge core_clk);
    second_mode_select <= dct_pkg::MODE_SPLIT;
    repeat (2) @(posedge core_clk);
    #1 c0 = {sh, sl};
    repeat (10) @(posedge core_clk); #1;
    chk({sh, sl}, c0, "second stopped");
    run_pulse(1'b1, 1);
    chk({fh, fl}, 16'h0000, "split high");
    chk({15'h0, second_overflow_flag}, 16'h0001, "high flag");
    @(posedge core_clk); #1;
    chk({15'h0, second_overflow_irq}, 16'h0001, "second irq");
    clr_flags();
    @(posedge core_clk);
    first_mode_select <= dct_pkg::MODE_16BIT;
    second_count_source_select <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 c0 = {sh, sl};
    run_pulse(1'b1, 10);
    chk({sh, sl}, c0, "mode3 inactive");
    $display("test split done");
  endtask : t_split

  // Second timer gate via polarity (its gate input tied low) and pin edges on its own count pin
  task automatic t_second();
    logic [15:0] c0;
    @(posedge core_clk);
    second_mode_select <= dct_pkg::MODE_13BIT;
    second_gate_bit <= 1'b1;
    second_gate_polarity <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 c0 = {sh, sl};
    run_pulse(1'b1, 4);
    chk({sh, sl}, c0, "second gate shut");
    @(posedge core_clk);
    second_gate_polarity <= 1'b0;
    repeat (3) @(posedge core_clk);
    run_pulse(1'b1, 4);
    chk({sh, sl} - c0, 16'h0004, "second gate open");
    @(posedge core_clk);
    second_count_source_select <= 1'b1;
    second_run_bit <= 1'b1;
    second_count_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    second_count_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    second_run_bit <= 1'b0;
    #1;
    chk({sh, sl} - c0, 16'h0005, "second pin fall");
    $display("test second timer done");
  endtask : t_second

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    err_count = 0;
    checks_done = 0;
    reset = 1'b1;
    {first_mode_select, second_mode_select, prescale_select} = 6'h00;
    {first_count_source_select, second_count_source_select} = 2'h0;
    {first_clock_select, second_clock_select} = 2'h0;
    {first_run_bit, second_run_bit, first_gate_bit} = 3'h0;
    {first_gate_polarity, first_gate_input, first_count_pin} = 3'h0;
    {second_gate_bit, second_gate_polarity, second_count_pin} = 3'h0;
    {first_overflow_irq_enable, second_overflow_irq_enable} = 2'h0;
    {first_overflow_flag_clr, second_overflow_flag_clr} = 2'h0;
    sw_wdata = 8'h00;
    we_v = 4'h0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk({fh, fl} | {sh, sl}, 16'h0000, "reset bytes");
    chk({14'h0, first_overflow_flag, second_overflow_flag}, 16'h0000,
        "rst flags");
    t_mode1();
    t_mode0_mode2();
    t_gate_pin();
    t_presc();
    t_split();
    t_second();
    give_verdict();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("[ERR] %0t run limit reached", $time);
    give_verdict();
  end

endmodule : dct_timers_test
`default_nettype wire
